// ==== rtl/hmp_pkg.sv ====
package hmp_pkg;
	localparam int DATA_W        = 24;
	localparam int BYTE_W        = 8;
	localparam int ADDR_W        = 9;
	localparam int ADDR_LSB      = 2;
	localparam int XFER_ADDR_W   = 22;
	localparam int BYTES_PER_WORD = 3;

	localparam logic [ADDR_W-1:0] BOOT_ADDR = 9'h1a0;
	localparam logic [ADDR_W-1:0] CTRL_ADDR = 9'h160;
	localparam logic [ADDR_W-1:0] NULL_ADDR = 9'h1b0;

	localparam int BOOT_CLK_SRC_BIT   = 5;
	localparam int CTRL_BYTE_MODE_BIT = 7;

	localparam logic [DATA_W-1:0] WORD_RESET = 24'h000000;
	localparam logic [1:0]        COUNT_ZERO = 2'h0;

	// timing: mclk period and the internal serial clock period
	localparam int CLK_PERIOD_NS   = 20;
	localparam int SCLK_PERIOD_NS  = 40;
	localparam int RW_SAMPLE_NS    = SCLK_PERIOD_NS / 2;
	localparam int RW_SAMPLE_CYC_R =
		(RW_SAMPLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RW_SAMPLE_CYC   =
		(RW_SAMPLE_CYC_R < 1) ? 1 : RW_SAMPLE_CYC_R;
	localparam int XFER_HOLD_CYC   = 2;
	localparam int CNT_W           = 4;

	typedef enum {
		ST_IDLE,
		ST_RW_WAIT,
		ST_FETCH,
		ST_DRIVE,
		ST_WR_WAIT,
		ST_CS_WAIT,
		ST_XFER_REQ,
		ST_XFER_DRIVE
	} hmp_state_e;

	typedef struct packed {
		logic              valid;
		logic              was_read;
		logic [ADDR_W-1:0] addr;
		logic [1:0]        count;
		logic [DATA_W-1:0] word;
	} hmp_hist_s;

	typedef struct packed {
		logic              rd;
		logic              wr;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} hmp_req_s;
endpackage

// ==== rtl/hmp_micro_port.sv ====
`timescale 1ns/1ps
module hmp_micro_port (
	input  wire logic                             mclk_i,
	input  wire logic                             resetn_i,
	input  wire logic                             chip_select_n_i,
	input  wire logic                             read_write_select_i,
	input  wire logic [hmp_pkg::DATA_W-1:0]       addr_data_bus_i,
	output logic      [hmp_pkg::DATA_W-1:0]       addr_data_bus_o,
	output logic                                  addr_data_bus_oe_o,
	output hmp_pkg::hmp_req_s                     reg_req_o,
	input  wire logic [hmp_pkg::DATA_W-1:0]       reg_rdata_i,
	output logic                                  byte_mode_o,
	output logic                                  clock_source_o,
	output logic      [hmp_pkg::DATA_W-1:0]       boot_config_o,
	output logic                                  boot_done_o,
	input  wire logic                             xfer_req_i,
	input  wire logic [hmp_pkg::XFER_ADDR_W-1:0]  xfer_addr_i,
	output logic                                  bus_request_o,
	input  wire logic                             bus_grant_i,
	output logic                                  xfer_done_o
);
	function automatic logic readable(input logic [hmp_pkg::ADDR_W-1:0] a);
		// boot is write-only and null is only a dummy location
		readable = (a != hmp_pkg::BOOT_ADDR) && (a != hmp_pkg::NULL_ADDR);
	endfunction

	function automatic logic is_ctrl(input logic [hmp_pkg::ADDR_W-1:0] a);
		is_ctrl = (a == hmp_pkg::CTRL_ADDR);
	endfunction

	hmp_pkg::hmp_state_e                  state, next_state;
	hmp_pkg::hmp_hist_s                   hist, next_hist;
	hmp_pkg::hmp_req_s                    next_reg_req;
	logic [hmp_pkg::ADDR_W-1:0]           addr, next_addr;
	logic [hmp_pkg::CNT_W-1:0]            cnt, next_cnt;
	logic                                 cs_q, rw_q;
	logic                                 next_cs_q, next_rw_q;
	logic [hmp_pkg::DATA_W-1:0]           bus_q, next_bus_q;
	logic [hmp_pkg::DATA_W-1:0]           next_bus;
	logic                                 next_oe;
	logic                                 next_byte_mode;
	logic                                 next_clock_source;
	logic [hmp_pkg::DATA_W-1:0]           next_boot_config;
	logic                                 next_boot_done;
	logic                                 next_bus_request;
	logic                                 next_xfer_done;
	logic                                 cs_fall, cs_rise, rw_rise;
	logic                                 rd_repeat;
	logic [hmp_pkg::DATA_W-1:0]           rot_word;
	logic [hmp_pkg::BYTE_W-1:0]           wbyte;
	logic [hmp_pkg::DATA_W-1:0]           wword;

	// host pins are sampled on mclk; edges are found against the prior sample
	assign cs_fall = cs_q && !chip_select_n_i;
	assign cs_rise = !cs_q && chip_select_n_i;
	assign rw_rise = !rw_q && read_write_select_i;
	// same address as the immediately preceding read, sequence unfinished
	assign rd_repeat = hist.valid && hist.was_read && (hist.addr == addr) &&
		(hist.count != 2'(hmp_pkg::BYTES_PER_WORD));
	assign rot_word = {hist.word[hmp_pkg::BYTE_W-1:0],
		hist.word[hmp_pkg::DATA_W-1:hmp_pkg::BYTE_W]};
	assign wbyte = bus_q[hmp_pkg::BYTE_W-1:0];
	assign wword = bus_q;

	// pin samples feed the edge detectors and hold write data one cycle
	always_comb begin
		next_cs_q  = chip_select_n_i;
		next_rw_q  = read_write_select_i;
		next_bus_q = addr_data_bus_i;
	end

	// strobes reset to their idle level, so release shows no false edge
	always_ff @(posedge mclk_i) begin
		if (!resetn_i) begin
			cs_q  <= 1'b1;
			rw_q  <= 1'b1;
			bus_q <= hmp_pkg::WORD_RESET;
		end else begin
			cs_q  <= next_cs_q;
			rw_q  <= next_rw_q;
			bus_q <= next_bus_q;
		end
	end

	always_comb begin
		next_state        = state;
		next_hist         = hist;
		next_addr         = addr;
		next_cnt          = cnt;
		next_reg_req      = reg_req_o;
		next_reg_req.rd   = 1'b0;
		next_reg_req.wr   = 1'b0;
		next_bus          = addr_data_bus_o;
		next_oe           = addr_data_bus_oe_o;
		next_byte_mode    = byte_mode_o;
		next_clock_source = clock_source_o;
		next_boot_config  = boot_config_o;
		next_boot_done    = boot_done_o;
		next_bus_request  = bus_request_o;
		next_xfer_done    = 1'b0;
		case (state)
			hmp_pkg::ST_IDLE: begin
				next_oe = 1'b0;
				if (cs_fall) begin
					// word address sits on lines 2..10
					next_addr = addr_data_bus_i[hmp_pkg::ADDR_LSB +:
						hmp_pkg::ADDR_W];
					next_cnt = hmp_pkg::CNT_W'(hmp_pkg::RW_SAMPLE_CYC);
					next_state = hmp_pkg::ST_RW_WAIT;
				end else if (xfer_req_i && chip_select_n_i) begin
					next_bus_request = 1'b1;
					next_state = hmp_pkg::ST_XFER_REQ;
				end
			end
			hmp_pkg::ST_RW_WAIT: begin
				if (chip_select_n_i) begin
					// strobe ended before the type was known: no effect
					next_state = hmp_pkg::ST_IDLE;
				end else if (cnt > hmp_pkg::CNT_W'(1)) begin
					next_cnt = cnt - hmp_pkg::CNT_W'(1);
				end else if (read_write_select_i) begin
					// read: decision taken half a serial period in
					if (byte_mode_o && rd_repeat) begin
						next_hist.word = rot_word;
						next_hist.count = hist.count + 2'h1;
						next_bus = {16'h0000,
							rot_word[hmp_pkg::BYTE_W-1:0]};
						next_oe = 1'b1;
						next_state = hmp_pkg::ST_DRIVE;
					end else if (readable(addr)) begin
						next_reg_req.rd = 1'b1;
						next_reg_req.addr = addr;
						next_state = hmp_pkg::ST_FETCH;
					end else begin
						// boot and null locations answer zero
						next_hist = '{1'b1, 1'b1, addr, 2'h1,
							hmp_pkg::WORD_RESET};
						next_bus = hmp_pkg::WORD_RESET;
						next_oe = 1'b1;
						next_state = hmp_pkg::ST_DRIVE;
					end
				end else begin
					next_state = hmp_pkg::ST_WR_WAIT;
				end
			end
			hmp_pkg::ST_FETCH: begin
				// a read aborts any pending write sequence
				next_hist = '{1'b1, 1'b1, addr, 2'h1, reg_rdata_i};
				next_bus = byte_mode_o ?
					{16'h0000, reg_rdata_i[hmp_pkg::BYTE_W-1:0]} :
					reg_rdata_i;
				next_oe = 1'b1;
				next_state = hmp_pkg::ST_DRIVE;
			end
			hmp_pkg::ST_DRIVE: begin
				// read data stands until chip select is seen high
				if (chip_select_n_i) begin
					next_oe = 1'b0;
					next_state = hmp_pkg::ST_IDLE;
				end
			end
			hmp_pkg::ST_WR_WAIT: begin
				if (rw_rise || cs_rise) begin
					if (chip_select_n_i) begin
						next_state = hmp_pkg::ST_IDLE;
					end else begin
						next_state = hmp_pkg::ST_CS_WAIT;
					end
					if (addr == hmp_pkg::BOOT_ADDR) begin
						next_clock_source =
							wword[hmp_pkg::BOOT_CLK_SRC_BIT];
						next_boot_config = wword;
						next_boot_done = 1'b1;
						next_hist.valid = 1'b0;
					end else if (!byte_mode_o) begin
						next_hist.valid = 1'b0;
						if (addr != hmp_pkg::NULL_ADDR) begin
							next_reg_req.wr = 1'b1;
							next_reg_req.addr = addr;
							next_reg_req.wdata = wword;
						end
						if (is_ctrl(addr)) begin
							next_byte_mode =
								wword[hmp_pkg::CTRL_BYTE_MODE_BIT];
						end
					end else if (hist.valid && !hist.was_read &&
						hist.addr == addr) begin
						next_hist.count = hist.count + 2'h1;
						if (hist.count == 2'h1) begin
							next_hist.word[15:8] = wbyte;
						end else begin
							// third byte of one address stores the word
							next_hist.word[23:16] = wbyte;
							next_hist.valid = 1'b0;
							if (addr != hmp_pkg::NULL_ADDR) begin
								next_reg_req.wr = 1'b1;
								next_reg_req.addr = addr;
								next_reg_req.wdata = {wbyte,
									hist.word[15:0]};
							end
							if (is_ctrl(addr)) begin
								next_byte_mode = hist.word[
									hmp_pkg::CTRL_BYTE_MODE_BIT];
							end
						end
					end else begin
						// new address or prior read drops the old bytes
						next_hist = '{1'b1, 1'b0, addr, 2'h1,
							{16'h0000, wbyte}};
					end
				end
			end
			hmp_pkg::ST_CS_WAIT: begin
				// write taken early; wait out the rest of the strobe
				if (chip_select_n_i) begin
					next_state = hmp_pkg::ST_IDLE;
				end
			end
			hmp_pkg::ST_XFER_REQ: begin
				// byte history is left untouched across transfers
				// a host strobe begun now is missed: the host must wait
				if (bus_grant_i) begin
					next_bus = {xfer_addr_i, 2'b00};
					next_oe = 1'b1;
					next_cnt = hmp_pkg::CNT_W'(hmp_pkg::XFER_HOLD_CYC);
					next_state = hmp_pkg::ST_XFER_DRIVE;
				end
			end
			hmp_pkg::ST_XFER_DRIVE: begin
				// row address stands for the hold count, then the bus frees
				if (cnt > hmp_pkg::CNT_W'(1)) begin
					next_cnt = cnt - hmp_pkg::CNT_W'(1);
				end else begin
					next_oe = 1'b0;
					next_bus_request = 1'b0;
					next_xfer_done = 1'b1;
					next_state = hmp_pkg::ST_IDLE;
				end
			end
			default: begin
				next_state = hmp_pkg::ST_IDLE;
			end
		endcase
	end

	// sequencer state and every top output
	always_ff @(posedge mclk_i) begin
		if (!resetn_i) begin
			state              <= hmp_pkg::ST_IDLE;
			hist               <= '0;
			addr               <= '0;
			cnt                <= '0;
			reg_req_o          <= '0;
			addr_data_bus_o    <= hmp_pkg::WORD_RESET;
			addr_data_bus_oe_o <= 1'b0;
			byte_mode_o        <= 1'b0;
			clock_source_o     <= 1'b0;
			boot_config_o      <= hmp_pkg::WORD_RESET;
			boot_done_o        <= 1'b0;
			bus_request_o      <= 1'b0;
			xfer_done_o        <= 1'b0;
		end else begin
			state              <= next_state;
			hist               <= next_hist;
			addr               <= next_addr;
			cnt                <= next_cnt;
			reg_req_o          <= next_reg_req;
			addr_data_bus_o    <= next_bus;
			addr_data_bus_oe_o <= next_oe;
			byte_mode_o        <= next_byte_mode;
			clock_source_o     <= next_clock_source;
			boot_config_o      <= next_boot_config;
			boot_done_o        <= next_boot_done;
			bus_request_o      <= next_bus_request;
			xfer_done_o        <= next_xfer_done;
		end
	end
endmodule

// ==== sim/hmp_micro_port_chk.sv ====
`timescale 1ns/1ps
module hmp_micro_port_chk (
	input wire logic              mclk_i,
	input wire logic              resetn_i,
	input wire logic              chip_select_n_i,
	input wire logic              read_write_select_i,
	input wire logic [23:0]       addr_data_bus_i,
	input wire logic [23:0]       addr_data_bus_o,
	input wire logic              addr_data_bus_oe_o,
	input wire hmp_pkg::hmp_req_s reg_req_o,
	input wire logic [23:0]       reg_rdata_i,
	input wire logic              byte_mode_o,
	input wire logic              boot_done_o,
	input wire logic              bus_request_o,
	input wire logic              bus_grant_i,
	input wire logic              xfer_done_o,
	input wire logic [21:0]       xfer_addr_i
);
	wire              cs = chip_select_n_i;
	wire              oe = addr_data_bus_oe_o;
	wire logic [23:0] bo = addr_data_bus_o;
	wire logic [23:0] bi = addr_data_bus_i;
	default clocking cb @(posedge mclk_i); endclocking
	sequence s_rd_start;
		$fell(cs) && !byte_mode_o && bi[10:2] != hmp_pkg::BOOT_ADDR &&
		bi[10:2] != hmp_pkg::NULL_ADDR ##1 read_write_select_i && !cs;
	endsequence
	sequence s_xfer_drive;
		oe && bo == {$past(xfer_addr_i), 2'h0} ##1 oe
		##1 !oe && xfer_done_o && !bus_request_o;
	endsequence
	property p_word_read;
		disable iff (!resetn_i) s_rd_start |=> reg_req_o.rd &&
		reg_req_o.addr == $past(bi[10:2], 2) ##1 oe && bo == $past(reg_rdata_i);
	endproperty
	a_word_read: assert property (p_word_read) else $error("word read");
	property p_oe_release;
		disable iff (!resetn_i) $rose(cs) |=> !oe;
	endproperty
	a_oe_release: assert property (p_oe_release) else $error("oe held");
	property p_rdata_hold;
		disable iff (!resetn_i) oe && $past(oe) && !cs |-> $stable(bo);
	endproperty
	a_rdata_hold: assert property (p_rdata_hold) else $error("data moved");
	property p_no_fwd;
		disable iff (!resetn_i) reg_req_o.rd || reg_req_o.wr |->
		reg_req_o.addr != hmp_pkg::NULL_ADDR &&
		reg_req_o.addr != hmp_pkg::BOOT_ADDR;
	endproperty
	a_no_fwd: assert property (p_no_fwd) else $error("bad forward");
	property p_xfer;
		disable iff (!resetn_i)
		bus_request_o && bus_grant_i && !oe && cs |=> s_xfer_drive;
	endproperty
	a_xfer: assert property (p_xfer) else $error("transfer cycle");
	property p_done_pulse;
		disable iff (!resetn_i) xfer_done_o |=> !xfer_done_o;
	endproperty
	a_done_pulse: assert property (p_done_pulse) else $error("done width");
	property p_boot_sticky;
		disable iff (!resetn_i) boot_done_o |=> boot_done_o;
	endproperty
	a_boot_sticky: assert property (p_boot_sticky) else $error("boot lost");
	property p_reset_word;
		!resetn_i |=> !byte_mode_o && !oe && !boot_done_o;
	endproperty
	a_reset_word: assert property (p_reset_word) else $error("reset state");
endmodule
bind hmp_micro_port hmp_micro_port_chk u_chk (.mclk_i, .resetn_i,
	.chip_select_n_i, .read_write_select_i, .addr_data_bus_i,
	.addr_data_bus_o, .addr_data_bus_oe_o, .reg_req_o, .reg_rdata_i,
	.byte_mode_o, .boot_done_o, .bus_request_o, .bus_grant_i,
	.xfer_done_o, .xfer_addr_i);

// ==== sim/hmp_host_model.sv ====
`timescale 1ns/1ps
module hmp_host_model (
	input  wire logic        mclk_i,
	input  wire logic        oe_i,
	input  wire logic [23:0] bus_i,
	output logic             chip_select_n_o,
	output logic             read_write_select_o,
	output logic [23:0]      bus_o
);
	initial begin
		chip_select_n_o = 1'h1;
		read_write_select_o = 1'h1;
		bus_o = 24'h0;
	end
	// released lanes show the inverse of the last value
	task automatic access(input logic r, input logic [8:0] a,
		input logic [23:0] d, output logic [23:0] q);
		int n;
		n = 0;
		@(posedge mclk_i) #1;
		chip_select_n_o = 1'h0;
		read_write_select_o = r;
		bus_o = {13'h0, a, 2'h0};
		repeat (2) @(posedge mclk_i) #1;
		bus_o = r ? ~bus_o : d;
		do @(posedge mclk_i) #1;
		while (r && oe_i !== 1'h1 && ++n < 20);
		@(posedge mclk_i) #1;
		q = bus_i;
		chip_select_n_o = 1'h1;
		bus_o = ~bus_o;
		repeat (2) @(posedge mclk_i) #1;
	endtask
endmodule

// ==== sim/tb_top.sv ====
`timescale 1ns/1ps
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin mismatches++; \
	$display("[ERR] %0t got %h exp %h", $time, a, e); end end
module tb_top;
	logic        mclk_i, resetn_i, xfer_req, grant, cs_n, rw, oe, bmode;
	logic        csrc, bdone, breq, xdone;
	logic [23:0] hbus, dbus, bus, rdata, q, boot;
	logic [21:0] xaddr;
	logic [23:0] mem [512];
	hmp_pkg::hmp_req_s req;
	int          mismatches, total_checks, n;
	logic [32:0] rows [3] = '{{9'h000, 24'h123456}, {9'h0ff, 24'hfedcba},
		{9'h121, 24'h00a5c3}};
	assign bus = oe ? dbus : hbus;
	assign rdata = mem[req.addr];
	always @(posedge mclk_i) if (req.wr) mem[req.addr] <= req.wdata;
	hmp_micro_port dut (.mclk_i, .resetn_i, .chip_select_n_i(cs_n),
		.read_write_select_i(rw), .addr_data_bus_i(bus),
		.addr_data_bus_o(dbus), .addr_data_bus_oe_o(oe), .reg_req_o(req),
		.reg_rdata_i(rdata), .byte_mode_o(bmode), .clock_source_o(csrc),
		.boot_config_o(boot), .boot_done_o(bdone), .xfer_req_i(xfer_req),
		.xfer_addr_i(xaddr), .bus_request_o(breq), .bus_grant_i(grant),
		.xfer_done_o(xdone));
	hmp_host_model host (.mclk_i, .oe_i(oe), .bus_i(bus),
		.chip_select_n_o(cs_n), .read_write_select_o(rw), .bus_o(hbus));
	initial begin
		mclk_i = 1'h0;
		forever #10 mclk_i = ~mclk_i;
	end
	task complete_run;
		if (mismatches == 0 && total_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic acc(input logic r, input logic [8:0] a, input logic [23:0] d);
		host.access(r, a, d, q);
	endtask
	initial begin
		#100000;
		mismatches++;
		complete_run;
	end
	initial begin
		resetn_i = 1'h0;
		xfer_req = 1'h0;
		grant = 1'h0;
		xaddr = 22'h2a5c3f;
		repeat (6) @(posedge mclk_i);
		#1 resetn_i = 1'h1;
		acc(1'h0, hmp_pkg::BOOT_ADDR, 24'h000020);
		`CHK(csrc, 1'h1)
		`CHK(boot, 24'h000020)
		acc(1'h1, hmp_pkg::BOOT_ADDR, 24'h0);
		`CHK(q, 24'h0)
		foreach (rows[i]) acc(1'h0, rows[i][32:24], rows[i][23:0]);
		foreach (rows[i]) begin
			acc(1'h1, rows[i][32:24], 24'h0);
			`CHK(q, rows[i][23:0])
		end
		acc(1'h0, hmp_pkg::CTRL_ADDR, 24'h000080);
		`CHK(bmode, 1'h1)
		acc(1'h1, hmp_pkg::NULL_ADDR, 24'h0);
		acc(1'h0, 9'h0ff, 24'h11);
		acc(1'h0, 9'h0ff, 24'h22);
		for (int i = 0; i < 3; i++) acc(1'h0, 9'h000, 24'h33 + 24'h11 * i);
		`CHK(mem[9'h0ff], 24'hfedcba)
		`CHK(mem[9'h000], 24'h554433)
		for (int i = 0; i < 4; i++) begin
			acc(1'h1, 9'h000, 24'h0);
			`CHK(q[7:0], 8'(8'h33 + 8'h11 * (i % 3)))
		end
		acc(1'h1, 9'h0ff, 24'h0);
		`CHK(q[7:0], 8'hba)
		for (int i = 0; i < 3; i++) acc(1'h0, 9'h0ff, 24'h66 + 24'h11 * i);
		`CHK(mem[9'h0ff], 24'h887766)
		xfer_req = 1'h1;
		n = 0;
		while (breq !== 1'h1 && n++ < 50) @(posedge mclk_i) #1;
		grant = 1'h1;
		while (xdone !== 1'h1 && n++ < 50) @(posedge mclk_i) #1;
		`CHK(xdone, 1'h1)
		xfer_req = 1'h0;
		grant = 1'h0;
		acc(1'h1, 9'h0ff, 24'h0);
		`CHK(q[7:0], 8'h66)
		acc(1'h1, hmp_pkg::NULL_ADDR, 24'h0);
		for (int i = 0; i < 3; i++)
			acc(1'h0, hmp_pkg::CTRL_ADDR, (i == 0) ? 24'h80 : 24'h00);
		`CHK(mem[hmp_pkg::CTRL_ADDR], 24'h000080)
		`CHK(bmode, 1'h1)
		acc(1'h1, hmp_pkg::NULL_ADDR, 24'h0);
		resetn_i = 1'h0;
		repeat (2) @(posedge mclk_i) #1;
		`CHK(bmode, 1'h0)
		`CHK(bdone, 1'h0)
		resetn_i = 1'h1;
		acc(1'h0, hmp_pkg::BOOT_ADDR, 24'h000000);
		`CHK(bdone, 1'h1)
		`CHK(csrc, 1'h0)
		acc(1'h1, 9'h0ff, 24'h0);
		`CHK(q, 24'h887766)
		complete_run;
	end
endmodule
